// >>> src/pawc_defs.svh
// Constants of the pager address word converter
`ifndef PAWC_DEFS_SVH
`define PAWC_DEFS_SVH
`define PAWC_AW 33
`define PAWC_WW 21
`define PAWC_SHORT_OFS 33'h0_0000_8000
`define PAWC_SHORT_LIM 33'h0_001e_ffff
`define PAWC_LONG_LO 33'h0_0020_1001
`define PAWC_LONG_MID 33'h0_4020_1001
`define PAWC_LONG_HI 33'h0_c020_1001
`define PAWC_LONG_MAX 33'h1_0020_0ffe
`define PAWC_BASE_A 33'h0_001f_9001
`define PAWC_BASE_A_REV 33'h0_001f_9000
`define PAWC_BASE_C 33'h0_001f_8fff
`define PAWC_W2_ONES 21'h1f_ffff
`define PAWC_W2_MID 21'h1d_8000
`define PAWC_W1_HI 21'h1f_7fff
`define PAWC_W2_HI 21'h1c_8000
`define PAWC_MOD_BITS 15
`define PAWC_SHORT_TOP 33'h0_001d_8000
`define PAWC_ILL1_TOP 33'h0_001e_8000
`define PAWC_RSV1_TOP 33'h0_001e_a7ff
`define PAWC_INFO_TOP 33'h0_001e_e7ff
`define PAWC_NET_TOP 33'h0_001e_f7ff
`define PAWC_TMP_TOP 33'h0_001e_f80f
`define PAWC_OPR_TOP 33'h0_001e_f81f
`define PAWC_RSV2_TOP 33'h0_001e_fffe
`define PAWC_UNCO_TOP 33'h0_0615_f102
`define PAWC_CTRY_TOP 33'h0_17f7_9402
`define PAWC_G13_TOP 33'h0_8020_1000
`define PAWC_C23_TOP 33'h0_e9d9_371e
`define PAWC_R23_TOP 33'h0_ff1b_9e00
`define PAWC_IG_TOP 33'h0_ff67_e940
`define PAWC_IC_TOP 33'h0_ffb4_3480
`define PAWC_IW_TOP 33'h0_ffc3_76c0
`define PAWC_PH_LSB 2
`define PAWC_FR_LSB 4
`endif

// >>> src/pawc_pkg.sv
// Types of the pager address word converter
package pawc_pkg;
  typedef enum logic [1:0] {PAWC_SHORT, PAWC_LONG_LOW, PAWC_LONG_MID, PAWC_LONG_HIGH} pawc_range_t;
  typedef enum logic [4:0] {
    PAWC_CL_ILLEGAL, PAWC_CL_SHORT, PAWC_CL_RESERVED, PAWC_CL_INFO, PAWC_CL_NETWORK,
    PAWC_CL_TEMP, PAWC_CL_OPERATOR, PAWC_CL_L12_UNCOORD, PAWC_CL_L12_COUNTRY,
    PAWC_CL_L12_GLOBAL, PAWC_CL_L13_GLOBAL, PAWC_CL_L14_GLOBAL, PAWC_CL_L23_COUNTRY,
    PAWC_CL_L23_RESERVED, PAWC_CL_L23_INFO_GLOBAL, PAWC_CL_L23_INFO_COUNTRY,
    PAWC_CL_L23_INFO_WORLD, PAWC_CL_UNDEFINED
  } pawc_class_t;
  typedef enum logic [1:0] {PAWC_SINGLE, PAWC_ANY, PAWC_ALL} pawc_unit_t;
  typedef struct packed {
    logic [32:0] value;
    logic [4:0] letter;
  } pawc_fwd_req_t;
  typedef struct packed {
    logic [20:0] word1;
    logic [20:0] word2;
    logic two_words;
  } pawc_words_t;
  typedef struct packed {
    logic [1:0] phase;
    logic [6:0] frame;
    logic derived;
    logic unit_valid;
    pawc_unit_t unit;
  } pawc_slot_t;
endpackage : pawc_pkg

// >>> src/pawc_classify.sv
// Address usage classifier
`timescale 1ns/1ps
`default_nettype none
`include "pawc_defs.svh"
module pawc_classify
  import pawc_pkg::*;
(
  input wire logic [32:0] value, // Address value
  output pawc_pkg::pawc_class_t cls // Usage class
);
  always_comb
  begin
    if (value == '0) cls = PAWC_CL_ILLEGAL;
    else if (value <= `PAWC_SHORT_TOP) cls = PAWC_CL_SHORT;
    else if (value <= `PAWC_ILL1_TOP) cls = PAWC_CL_ILLEGAL;
    else if (value <= `PAWC_RSV1_TOP) cls = PAWC_CL_RESERVED;
    else if (value <= `PAWC_INFO_TOP) cls = PAWC_CL_INFO;
    else if (value <= `PAWC_NET_TOP) cls = PAWC_CL_NETWORK;
    else if (value <= `PAWC_TMP_TOP) cls = PAWC_CL_TEMP;
    else if (value <= `PAWC_OPR_TOP) cls = PAWC_CL_OPERATOR;
    else if (value <= `PAWC_RSV2_TOP) cls = PAWC_CL_RESERVED;
    else if (value < `PAWC_LONG_LO) cls = PAWC_CL_ILLEGAL;
    else if (value <= `PAWC_UNCO_TOP) cls = PAWC_CL_L12_UNCOORD;
    else if (value <= `PAWC_CTRY_TOP) cls = PAWC_CL_L12_COUNTRY;
    else if (value < `PAWC_LONG_MID) cls = PAWC_CL_L12_GLOBAL;
    else if (value <= `PAWC_G13_TOP) cls = PAWC_CL_L13_GLOBAL;
    else if (value < `PAWC_LONG_HI) cls = PAWC_CL_L14_GLOBAL;
    else if (value <= `PAWC_C23_TOP) cls = PAWC_CL_L23_COUNTRY;
    else if (value <= `PAWC_R23_TOP) cls = PAWC_CL_L23_RESERVED;
    else if (value <= `PAWC_IG_TOP) cls = PAWC_CL_L23_INFO_GLOBAL;
    else if (value <= `PAWC_IC_TOP) cls = PAWC_CL_L23_INFO_COUNTRY;
    else if (value <= `PAWC_IW_TOP) cls = PAWC_CL_L23_INFO_WORLD;
    else if (value <= `PAWC_LONG_MAX) cls = PAWC_CL_RESERVED;
    else cls = PAWC_CL_UNDEFINED;
  end
endmodule : pawc_classify
`default_nettype wire

// >>> src/pawc_slot.sv
// Frame and phase derivation from the class letter
`timescale 1ns/1ps
`default_nettype none
`include "pawc_defs.svh"
module pawc_slot
  import pawc_pkg::*;
(
  input wire logic [32:0] value, // Address value
  input wire logic [4:0] letter, // Class letter, 0 for A up to 25 for Z
  output pawc_pkg::pawc_slot_t slot // Unit type, frame and phase
);
  logic [32:0] adj;
  always_comb
  begin
    slot = '0;
    adj = value;
    if (letter <= 5'h0b)
    begin
      adj = value - {31'h0, letter[1:0]};
      slot.phase = adj[`PAWC_PH_LSB +: 2];
      slot.frame = adj[`PAWC_FR_LSB +: 7];
      slot.derived = 1'b1;
      slot.unit_valid = 1'b1;
      slot.unit = (letter[3:2] == 2'h0) ? PAWC_SINGLE :
                  (letter[3:2] == 2'h1) ? PAWC_ANY : PAWC_ALL;
    end
    else if (letter >= 5'h14 && letter <= 5'h17)
    begin
      slot.phase = 2'(letter - 5'h14);
      slot.unit_valid = 1'b1;
      slot.unit = PAWC_SINGLE;
    end
    else if (letter == 5'h18 || letter == 5'h19)
    begin
      slot.unit_valid = 1'b1;
      slot.unit = (letter == 5'h18) ? PAWC_ANY : PAWC_ALL;
    end
  end
endmodule : pawc_slot
`default_nettype wire

// >>> src/pawc_conv.sv
// Pager address word converter top
`timescale 1ns/1ps
`default_nettype none
`include "pawc_defs.svh"
module pawc_conv
  import pawc_pkg::*;
(
  input wire logic clk, // 100 MHz clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic fwd_req, // Forward conversion request pulse
  input wire pawc_pkg::pawc_fwd_req_t fwd_in, // Address value and class letter
  input wire logic rev_req, // Reverse conversion request pulse
  input wire pawc_pkg::pawc_words_t rev_in, // Received words
  output pawc_pkg::pawc_words_t fwd_words, // Forward result words
  output pawc_pkg::pawc_slot_t fwd_slot, // Frame and phase
  output pawc_pkg::pawc_class_t fwd_class, // Usage class
  output logic fwd_valid, // Forward result strobe
  output logic fwd_err, // Forward error
  output logic [32:0] rev_value, // Recovered address
  output logic rev_valid, // Reverse result strobe
  output logic rev_err // Reverse error
);
  import pawc_pkg::*;

  // ----------------------------------------
  // Range decoding
  // ----------------------------------------
  function automatic pawc_range_t range_of(input logic [32:0] v);
    if (v < `PAWC_SHORT_LIM) range_of = PAWC_SHORT;
    else if (v < `PAWC_LONG_MID) range_of = PAWC_LONG_LOW;
    else if (v < `PAWC_LONG_HI) range_of = PAWC_LONG_MID;
    else range_of = PAWC_LONG_HIGH;
  endfunction : range_of

  pawc_class_t cls;
  pawc_slot_t slot;
  pawc_classify u_cls (.value(fwd_in.value), .cls(cls));
  pawc_slot u_slot (.value(fwd_in.value), .letter(fwd_in.letter), .slot(slot));

  // ----------------------------------------
  // Forward arithmetic
  // ----------------------------------------
  logic [32:0] diff_a;
  logic [32:0] diff_c;
  logic [32:0] sum_s;
  pawc_words_t w_d;
  logic bad_d;
  always_comb
  begin
    diff_a = fwd_in.value - `PAWC_BASE_A;
    diff_c = fwd_in.value - `PAWC_BASE_C;
    sum_s = fwd_in.value + `PAWC_SHORT_OFS;
    w_d = '0;
    bad_d = (fwd_in.value == '0) || (cls == PAWC_CL_ILLEGAL) ||
            (fwd_in.value > `PAWC_LONG_MAX) ||
            (fwd_in.value >= `PAWC_SHORT_LIM && fwd_in.value < `PAWC_LONG_LO);
    unique case (range_of(fwd_in.value))
      PAWC_SHORT: w_d.word1 = sum_s[20:0];
      PAWC_LONG_LOW:
      begin
        w_d.word1 = {6'h0, diff_a[14:0]} + 21'h1;
        w_d.word2 = `PAWC_W2_ONES - {3'h0, diff_a[`PAWC_AW - 1:`PAWC_MOD_BITS]};
        w_d.two_words = 1'b1;
      end
      PAWC_LONG_MID:
      begin
        w_d.word1 = {6'h0, diff_a[14:0]} + 21'h1;
        w_d.word2 = {3'h0, diff_a[`PAWC_AW - 1:`PAWC_MOD_BITS]} + `PAWC_W2_MID;
        w_d.two_words = 1'b1;
      end
      PAWC_LONG_HIGH:
      begin
        w_d.word1 = {6'h0, diff_c[14:0]} + `PAWC_W1_HI;
        w_d.word2 = {3'h0, diff_c[`PAWC_AW - 1:`PAWC_MOD_BITS]} + `PAWC_W2_HI;
        w_d.two_words = 1'b1;
      end
    endcase
    if (bad_d) w_d = '0;
  end

  // ----------------------------------------
  // Reverse arithmetic
  // ----------------------------------------
  logic [32:0] q_r;
  logic [32:0] v_r;
  logic bad_r;
  always_comb
  begin
    q_r = '0;
    v_r = '0;
    bad_r = 1'b0;
    if (!rev_in.two_words)
    begin
      v_r = {12'h0, rev_in.word1} - `PAWC_SHORT_OFS;
      bad_r = ({12'h0, rev_in.word1} <= `PAWC_SHORT_OFS) ||
              (v_r >= `PAWC_SHORT_LIM);
    end
    else if (rev_in.word1 >= `PAWC_W1_HI)
    begin
      // Second words of the high set overlap the middle set; word one tells them apart
      q_r = {12'h0, rev_in.word2 - `PAWC_W2_HI};
      v_r = (q_r << `PAWC_MOD_BITS) + `PAWC_BASE_C +
            {12'h0, rev_in.word1 - `PAWC_W1_HI};
      bad_r = (rev_in.word2 < `PAWC_W2_HI) || (rev_in.word1 == `PAWC_W2_ONES);
    end
    else if (rev_in.word2 >= `PAWC_W1_HI)
    begin
      q_r = {12'h0, ~rev_in.word2};
      v_r = (q_r << `PAWC_MOD_BITS) + `PAWC_BASE_A_REV + {12'h0, rev_in.word1};
      bad_r = (rev_in.word1 == '0) || (rev_in.word1 > 21'h8000);
    end
    else
    begin
      q_r = {12'h0, rev_in.word2 - `PAWC_W2_MID};
      v_r = (q_r << `PAWC_MOD_BITS) + `PAWC_BASE_A_REV + {12'h0, rev_in.word1};
      bad_r = (rev_in.word2 < `PAWC_W2_MID) || (rev_in.word1 == '0) ||
              (rev_in.word1 > 21'h8000);
    end
  end

  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      fwd_words <= '0;
      fwd_slot <= '0;
      fwd_class <= PAWC_CL_ILLEGAL;
      fwd_err <= 1'b0;
    end
    else if (fwd_req)
    begin
      fwd_words <= w_d;
      fwd_slot <= slot;
      fwd_class <= cls;
      fwd_err <= bad_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst) fwd_valid <= 1'b0;
    else fwd_valid <= fwd_req;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rev_value <= '0;
      rev_err <= 1'b0;
    end
    else if (rev_req)
    begin
      rev_value <= bad_r ? '0 : v_r;
      rev_err <= bad_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst) rev_valid <= 1'b0;
    else rev_valid <= rev_req;
  end
endmodule : pawc_conv
`default_nettype wire

// >>> testbench/pawc_host_model.sv
// Requesting logic model for the address word converter
`timescale 1ns/1ps
`default_nettype none
module pawc_host_model
  import pawc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic fwd_valid, // Forward strobe
  input wire logic rev_valid, // Reverse strobe
  output logic fwd_req, // Forward request
  output pawc_pkg::pawc_fwd_req_t fwd_in, // Forward operands
  output logic rev_req, // Reverse request
  output pawc_pkg::pawc_words_t rev_in // Received words
);
  initial
  begin
    fwd_req = 1'b0;
    rev_req = 1'b0;
    fwd_in = '0;
    rev_in = '0;
  end
  // ----------------------------------------
  // One request, held for one clock cycle, then the strobe is sampled once
  // ----------------------------------------
  task automatic xfer(input logic kind, input pawc_fwd_req_t f, input pawc_words_t w,
                      output logic got);
    @(negedge clk);
    fwd_req = !kind;
    rev_req = kind;
    if (kind) rev_in = w; else fwd_in = f;
    @(negedge clk);
    fwd_req = 1'b0;
    rev_req = 1'b0;
    got = kind ? rev_valid : fwd_valid;
    @(negedge clk);
    if (kind) rev_in = ~w; else fwd_in = ~f;
  endtask : xfer
endmodule : pawc_host_model
`default_nettype wire

// >>> testbench/pawc_conv_assertions.sv
// Assertion checker for the address word converter
`timescale 1ns/1ps
`default_nettype none
`include "pawc_defs.svh"
module pawc_conv_assertions
  import pawc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic nrst, // Reset
  input wire logic fwd_req, // Fwd request
  input wire pawc_pkg::pawc_fwd_req_t fwd_in, // Fwd operands
  input wire logic rev_req, // Rev request
  input wire pawc_pkg::pawc_words_t rev_in, // Rev words
  input wire pawc_pkg::pawc_words_t fwd_words, // Fwd words
  input wire pawc_pkg::pawc_slot_t fwd_slot, // Slot
  input wire logic fwd_valid, // Fwd strobe
  input wire logic fwd_err, // Fwd error
  input wire logic [32:0] rev_value, // Rev address
  input wire logic rev_valid, // Rev strobe
  input wire logic rev_err // Rev error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_fwd_ans;
    fwd_req |=> fwd_valid;
  endproperty
  a_fwd_ans: assert property (p_fwd_ans) else $error("fwd answer missing");
  property p_fwd_cause;
    fwd_valid |-> $past(fwd_req);
  endproperty
  a_fwd_cause: assert property (p_fwd_cause) else $error("fwd strobe uncaused");
  property p_rev_ans;
    rev_req |=> rev_valid;
  endproperty
  a_rev_ans: assert property (p_rev_ans) else $error("rev answer missing");
  property p_err_zero;
    fwd_valid && fwd_err |-> fwd_words == '0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("words on error");
  property p_short;
    fwd_valid && $past(fwd_in.value) != '0 && $past(fwd_in.value) <= `PAWC_SHORT_TOP |->
      !fwd_err && !fwd_words.two_words && fwd_words.word1 == 21'($past(fwd_in.value) + `PAWC_SHORT_OFS);
  endproperty
  a_short: assert property (p_short) else $error("short word wrong");
  property p_low_w1;
    fwd_valid && !fwd_err && fwd_words.two_words && $past(fwd_in.value) < `PAWC_LONG_MID |->
      fwd_words.word1 == 21'(($past(fwd_in.value) - `PAWC_BASE_A) & 33'h7fff) + 21'h1;
  endproperty
  a_low_w1: assert property (p_low_w1) else $error("low first word wrong");
  property p_phase_a;
    fwd_valid && !fwd_err && $past(fwd_in.letter) == 5'h0 |->
      fwd_slot.phase == $past(fwd_in.value[3:2]) && fwd_slot.frame == $past(fwd_in.value[10:4]);
  endproperty
  a_phase_a: assert property (p_phase_a) else $error("standard slot wrong");
  property p_rev_short;
    rev_valid && !rev_err && !$past(rev_in.two_words) |->
      rev_value == 33'($past(rev_in.word1)) - `PAWC_SHORT_OFS;
  endproperty
  a_rev_short: assert property (p_rev_short) else $error("rev short wrong");
endmodule : pawc_conv_assertions
bind pawc_conv pawc_conv_assertions u_chk (.clk, .nrst, .fwd_req, .fwd_in, .rev_req, .rev_in,
  .fwd_words, .fwd_slot, .fwd_valid, .fwd_err, .rev_value, .rev_valid, .rev_err);
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking testbench for the address word converter
`timescale 1ns/1ps
`default_nettype none
`include "pawc_defs.svh"
module tb_top;
  import pawc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic fwd_req, rev_req, fwd_valid, fwd_err, rev_valid, rev_err, got;
  pawc_fwd_req_t fwd_in;
  pawc_words_t rev_in, fwd_words, ew;
  pawc_slot_t fwd_slot;
  pawc_class_t fwd_class;
  logic [32:0] rev_value;
  int fail_count = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  pawc_conv u_dut (.clk, .nrst, .fwd_req, .fwd_in, .rev_req, .rev_in, .fwd_words, .fwd_slot,
    .fwd_class, .fwd_valid, .fwd_err, .rev_value, .rev_valid, .rev_err);
  pawc_host_model u_host (.clk, .fwd_valid, .rev_valid, .fwd_req, .fwd_in, .rev_req, .rev_in);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic fwd(input logic [32:0] v, input logic [4:0] l);
    u_host.xfer(1'b0, '{v, l}, '0, got);
    chk("fwd_valid", got, 1);
  endtask : fwd
  function automatic pawc_words_t exp_w(input logic [32:0] v);
    logic [32:0] d;
    d = v - ((v < `PAWC_LONG_HI) ? `PAWC_BASE_A : `PAWC_BASE_C);
    if (v < `PAWC_LONG_LO) return '{21'(v + `PAWC_SHORT_OFS), 21'h0, 1'b0};
    if (v < `PAWC_LONG_MID) return '{21'(d[14:0]) + 21'h1, `PAWC_W2_ONES - 21'(d >> 15), 1'b1};
    if (v < `PAWC_LONG_HI) return '{21'(d[14:0]) + 21'h1, 21'(d >> 15) + `PAWC_W2_MID, 1'b1};
    return '{21'(d[14:0]) + `PAWC_W1_HI, 21'(d >> 15) + `PAWC_W2_HI, 1'b1};
  endfunction : exp_w
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_conv;
    logic [32:0] vs [9] = '{33'h1, `PAWC_SHORT_TOP, 33'h0_001e_f800, `PAWC_LONG_LO,
      `PAWC_LONG_MID - 33'h1, `PAWC_LONG_MID, `PAWC_LONG_HI - 33'h1, `PAWC_LONG_HI, `PAWC_LONG_MAX};
    foreach (vs[i])
    begin
      fwd(vs[i], 5'h0);
      ew = exp_w(vs[i]);
      chk("fwd_words", fwd_words, ew);
      chk("fwd_err", fwd_err, 0);
      u_host.xfer(1'b1, '0, ew, got);
      chk("rev_valid", got, 1);
      chk("rev_value", rev_value, vs[i]);
    end
  endtask : t_conv
  task automatic t_edges;
    logic [32:0] vs [9] = '{33'h0, `PAWC_SHORT_LIM, `PAWC_LONG_LO - 33'h1, `PAWC_LONG_LO,
      33'h0_0615_f102, 33'h0_0615_f103, `PAWC_LONG_MAX + 33'h1, 33'h0_e9d9_371e, 33'h0_e9d9_371f};
    pawc_class_t cs [9] = '{PAWC_CL_ILLEGAL, PAWC_CL_ILLEGAL, PAWC_CL_ILLEGAL, PAWC_CL_L12_UNCOORD,
      PAWC_CL_L12_UNCOORD, PAWC_CL_L12_COUNTRY, PAWC_CL_UNDEFINED, PAWC_CL_L23_COUNTRY,
      PAWC_CL_L23_RESERVED};
    logic es [9] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    foreach (vs[i])
    begin
      fwd(vs[i], 5'h4);
      chk("fwd_class", fwd_class, cs[i]);
      chk("fwd_err", fwd_err, es[i]);
      if (es[i]) chk("fwd_words", fwd_words, 0);
    end
    u_host.xfer(1'b1, '0, '{21'h00_8000, 21'h0, 1'b0}, got);
    chk("rev_err", rev_err, 1);
    chk("rev_value", rev_value, 0);
    u_host.xfer(1'b1, '0, '{`PAWC_W1_HI, 21'h0, 1'b1}, got);
    chk("rev_err", rev_err, 1);
    chk("rev_value", rev_value, 0);
  endtask : t_edges
  task automatic t_letters;
    logic [32:0] a;
    for (int l = 0; l < 26; l++)
    begin
      fwd(33'h0_0000_1230, 5'(l));
      a = 33'h0_0000_1230 - 33'(l % 4);
      chk("unit_valid", fwd_slot.unit_valid, l < 12 || l > 19);
      if (l < 12)
      begin
        chk("phase", fwd_slot.phase, a[3:2]);
        chk("frame", fwd_slot.frame, a[10:4]);
        chk("unit", fwd_slot.unit, l / 4);
        chk("derived", fwd_slot.derived, 1);
      end
      else if (l > 19)
      begin
        chk("unit", fwd_slot.unit, (l < 24) ? 0 : l - 23);
        chk("derived", fwd_slot.derived, 0);
        if (l < 24) chk("phase", fwd_slot.phase, l - 20);
      end
    end
  endtask : t_letters
  // ----------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    t_conv;
    t_edges;
    t_letters;
    wrap_up;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    fail_count++;
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
